// ---- hdl/cmt_defines.svh ----
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH

// ==========================================
// Widths
`define CMT_OPTO_W    14
`define CMT_CONT_W    32
`define CMT_LED_W     18
`define CMT_BUS_W     1023
`define CMT_SEL_W     10
`define CMT_NPROBE    8
`define CMT_EV_W      4
`define CMT_CNT_W     28
// ==========================================
// Values and timing
`define CMT_SEL_MAX   10'h3FE
`define CMT_LED_ALL18 18'h3FFFF
`define CMT_LED_ALL8  18'h000FF
`define CMT_IEC103    1'b1
`define CMT_LAMP_MS   2000
`define CMT_CLK_KHZ   125000
// ==========================================
// Register byte offsets
`define CMT_OFS_OPTO  8'h00
`define CMT_OFS_CSTAT 8'h04
`define CMT_OFS_PROBE 8'h08
`define CMT_OFS_SEL0  8'h0C
`define CMT_OFS_SEL7  8'h28
`define CMT_OFS_MODE  8'h2C
`define CMT_OFS_MASK  8'h30
`define CMT_OFS_CCMD  8'h34
`define CMT_OFS_LAMP  8'h38
`define CMT_OFS_ISTS  8'h3C
`define CMT_OFS_IMSK  8'h40
`endif

// ---- hdl/cmt_pkg.sv ----
`include "cmt_defines.svh"
package cmt_pkg;
   // Test setting and contact command codes
   typedef enum logic [1:0] {
      CMT_MODE_OFF = 2'h0,
      CMT_MODE_OOS = 2'h1,
      CMT_MODE_BLK = 2'h2
   } cmt_mode_t;
   typedef enum logic [1:0] {
      CMT_CC_IDLE   = 2'h0,
      CMT_CC_APPLY  = 2'h1,
      CMT_CC_REMOVE = 2'h2
   } cmt_ccmd_t;
   // Module state records
   typedef struct packed {
      logic [`CMT_NPROBE-1:0][`CMT_SEL_W-1:0] sel;
      cmt_mode_t                             mode;
      logic [`CMT_CONT_W-1:0]                mask;
      logic [`CMT_CONT_W-1:0]                pat;
      logic [`CMT_CONT_W-1:0]                cout;
      logic [`CMT_CONT_W-1:0]                cstat;
      logic [31:0]                           rdata;
      logic                                  ex_on;
      logic [`CMT_LED_W-1:0]                 led;
      logic [`CMT_EV_W-1:0]                  ists;
      logic [`CMT_EV_W-1:0]                  imask;
      logic                                  lamp_go;
      logic                                  alarm;
   } cmt_top_st_t;
   typedef struct packed {
      logic val;
   } cmt_probe_st_t;
   typedef struct packed {
      logic                  active;
      logic                  done;
      logic [`CMT_CNT_W-1:0] cnt;
   } cmt_lamp_st_t;
endpackage

// ---- hdl/cmt_ctl_if.sv ----
`timescale 1ns/1ps
`include "cmt_defines.svh"
// ==========================================
// Links between controller, probes and lamp timer
interface cmt_ctl_if;
   logic [`CMT_NPROBE-1:0][`CMT_SEL_W-1:0] probe_sel;
   logic [`CMT_NPROBE-1:0]                 probe_val;
   logic                                   lamp_start;
   logic                                   lamp_active;
   logic                                   lamp_done;
   modport top   (output probe_sel, lamp_start, input probe_val, lamp_active, lamp_done);
   modport probe (input probe_sel, output probe_val);
   modport lamp  (input lamp_start, output lamp_active, lamp_done);
endinterface

// ---- hdl/cmt_probe.sv ----
`timescale 1ns/1ps
`include "cmt_defines.svh"
// ==========================================
// One probe: samples the selected bus signal
module cmt_probe #(
   parameter int IDX = 0
) (
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   input wire logic [`CMT_BUS_W-1:0] int_bus,
   cmt_ctl_if.probe                  ctl
);
   cmt_pkg::cmt_probe_st_t st_reg;
   cmt_pkg::cmt_probe_st_t st_next;

   // Pick the bus signal named by this selector
   always_comb begin
      st_next = st_reg;
      st_next.val = int_bus[ctl.probe_sel[IDX]];
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ctl.probe_val[IDX] = st_reg.val;

   a_probe_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> st_reg.val == $past(int_bus[ctl.probe_sel[IDX]]))
      else $error("probe does not follow selected signal");
endmodule

// ---- hdl/cmt_lamp.sv ----
`timescale 1ns/1ps
`include "cmt_defines.svh"
// ==========================================
// Lamp check interval timer
module cmt_lamp #(
   parameter int unsigned CYCLES = `CMT_LAMP_MS * `CMT_CLK_KHZ
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   cmt_ctl_if.lamp  ctl
);
   cmt_pkg::cmt_lamp_st_t st_reg;
   cmt_pkg::cmt_lamp_st_t st_next;

   // Count out the interval, pulse done at its end
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (st_reg.active) begin
         if (st_reg.cnt == `CMT_CNT_W'(CYCLES - 1)) begin
            st_next.active = 1'b0;
            st_next.done = 1'b1;
            st_next.cnt = '0;
         end else begin
            st_next.cnt = st_reg.cnt + `CMT_CNT_W'(1);
         end
      end else if (ctl.lamp_start) begin
         st_next.active = 1'b1;
         st_next.cnt = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ctl.lamp_active = st_reg.active;
   assign ctl.lamp_done = st_reg.done;

   a_lamp_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_reg.done |-> !st_reg.active && $past(st_reg.active) && $past(st_reg.cnt) == `CMT_CNT_W'(CYCLES - 1))
      else $error("lamp check ended at wrong count");
endmodule

// ---- hdl/cmt_top.sv ----
`timescale 1ns/1ps
`include "cmt_defines.svh"
// ==========================================
// Commissioning test controller
module cmt_top #(
   parameter int unsigned LAMP_CYCLES = `CMT_LAMP_MS * `CMT_CLK_KHZ
) (
   input  wire logic                   SYS_CLK,
   input  wire logic                   RST_N,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [11:0]            PADDR,
   input  wire logic [31:0]            PWDATA,
   output wire logic [31:0]            PRDATA,
   output wire logic                   PREADY,
   output wire logic                   PSLVERR,
   input  wire logic [`CMT_OPTO_W-1:0] OPTO_IN,
   input  wire logic [`CMT_CONT_W-1:0] CONTACT_FB,
   input  wire logic [`CMT_CONT_W-1:0] PROT_CONTACT_REQ,
   output wire logic [`CMT_CONT_W-1:0] CONTACT_OUT,
   input  wire logic [`CMT_BUS_W-1:0]  INT_BUS,
   output wire logic [`CMT_NPROBE-1:0] PROBE_OUT,
   input  wire logic [`CMT_LED_W-1:0]  LED_REQ,
   input  wire logic                   VARIANT_18,
   output wire logic [`CMT_LED_W-1:0]  LED_OUT,
   output wire logic                   OOS_LED,
   output wire logic                   PROT_OFF_ALARM,
   output wire logic                   MAINT_BLOCK,
   output wire logic                   CB_FREEZE,
   output wire logic                   TRANSMISSION_CAUSE_TEST,
   output wire logic                   ALARM_REC,
   output wire logic                   IRQ
);

   // ==========================================
   // State and local signals
   cmt_pkg::cmt_top_st_t st_reg;
   cmt_pkg::cmt_top_st_t st_next;

   logic                   acc;
   logic                   setup;
   logic                   wr;
   logic                   unmapped;
   logic                   bad_val;
   logic                   is_sel;
   logic [7:0]             ofs;
   logic [7:0]             sel_ofs;
   logic [2:0]             sel_idx;
   logic [`CMT_EV_W-1:0]   ev;
   logic [`CMT_EV_W-1:0]   clr;
   logic [`CMT_LED_W-1:0]  all_leds;
   logic                   blk;

   cmt_ctl_if ctl ();

   // ==========================================
   // Probe selectors and lamp timer
   genvar gi;
   generate
      for (gi = 0; gi < `CMT_NPROBE; gi++) begin : g_probe
         cmt_probe #(
            .IDX (gi)
         ) u_probe (
            .sys_clk (SYS_CLK),
            .rst_n   (RST_N),
            .int_bus (INT_BUS),
            .ctl     (ctl.probe)
         );
      end
   endgenerate

   cmt_lamp #(
      .CYCLES (LAMP_CYCLES)
   ) u_lamp (
      .sys_clk (SYS_CLK),
      .rst_n   (RST_N),
      .ctl     (ctl.lamp)
   );

   assign ctl.probe_sel = st_reg.sel;
   assign ctl.lamp_start = st_reg.lamp_go;

   // ==========================================
   // Bus decode
   assign setup = PSEL & ~PENABLE;
   assign acc = PSEL & PENABLE;
   assign wr = acc & PWRITE;
   assign ofs = PADDR[7:0];
   assign sel_ofs = ofs - `CMT_OFS_SEL0;
   assign sel_idx = sel_ofs[4:2];
   assign is_sel = (ofs >= `CMT_OFS_SEL0) && (ofs <= `CMT_OFS_SEL7);
   assign blk = (st_reg.mode == cmt_pkg::CMT_MODE_BLK);
   assign all_leds = VARIANT_18 ? `CMT_LED_ALL18 : `CMT_LED_ALL8;

   // Unmapped offsets and misaligned words
   always_comb begin
      unmapped = 1'b1;
      if ((PADDR[11:8] == 4'h0) && (PADDR[1:0] == 2'h0)) begin
         if (is_sel || (ofs <= `CMT_OFS_IMSK)) begin
            unmapped = 1'b0;
         end
      end
   end

   // Writes outside a field's legal codes
   always_comb begin
      bad_val = 1'b0;
      if (is_sel && (PWDATA[31:0] > {22'h0, `CMT_SEL_MAX})) begin
         bad_val = 1'b1;
      end
      if ((ofs == `CMT_OFS_MODE) && (PWDATA > 32'h00000002)) begin
         bad_val = 1'b1;
      end
      if ((ofs == `CMT_OFS_CCMD) && (PWDATA > 32'h00000002)) begin
         bad_val = 1'b1;
      end
   end

   assign PREADY = 1'b1;
   assign PSLVERR = acc & (unmapped | (PWRITE & bad_val));
   assign clr = (wr && !unmapped && ofs == `CMT_OFS_ISTS) ? PWDATA[`CMT_EV_W-1:0] : '0;

   // ==========================================
   // Next state
   always_comb begin
      st_next = st_reg;
      ev = '0;
      st_next.lamp_go = 1'b0;
      st_next.alarm = 1'b0;

      // Register writes on the access edge
      if (wr && !unmapped && !bad_val) begin
         if (is_sel) begin
            st_next.sel[sel_idx] = PWDATA[`CMT_SEL_W-1:0];
         end
         case (ofs)
            `CMT_OFS_MODE: begin
               st_next.mode = cmt_pkg::cmt_mode_t'(PWDATA[1:0]);
               if ((PWDATA[1:0] == cmt_pkg::CMT_MODE_OOS) && (st_reg.mode != cmt_pkg::CMT_MODE_OOS)) begin
                  st_next.alarm = 1'b1;
                  ev[0] = 1'b1;
               end
            end
            `CMT_OFS_MASK: begin
               st_next.mask = PWDATA[`CMT_CONT_W-1:0];
            end
            `CMT_OFS_CCMD: begin
               if (blk && (PWDATA[1:0] == cmt_pkg::CMT_CC_APPLY)) begin
                  st_next.ex_on = 1'b1;
                  st_next.pat = st_reg.mask;
                  ev[1] = 1'b1;
               end else if (blk && (PWDATA[1:0] == cmt_pkg::CMT_CC_REMOVE)) begin
                  st_next.ex_on = 1'b0;
                  st_next.pat = '0;
                  ev[2] = 1'b1;
               end
            end
            `CMT_OFS_LAMP: begin
               if (PWDATA[0] && !ctl.lamp_active) begin
                  st_next.lamp_go = 1'b1;
               end
            end
            `CMT_OFS_IMSK: begin
               st_next.imask = PWDATA[`CMT_EV_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Exercise only lives inside contact isolation
      if (st_next.mode != cmt_pkg::CMT_MODE_BLK) begin
         st_next.ex_on = 1'b0;
         st_next.pat = '0;
      end

      // Contact drive per test setting
      case (st_next.mode)
         cmt_pkg::CMT_MODE_OFF: begin
            st_next.cout = PROT_CONTACT_REQ;
         end
         cmt_pkg::CMT_MODE_OOS: begin
            st_next.cout = '0;
         end
         cmt_pkg::CMT_MODE_BLK: begin
            st_next.cout = st_next.ex_on ? st_next.pat : '0;
         end
         default: begin
            st_next.cout = '0;
         end
      endcase

      // Contact status tracks only in service
      if (st_reg.mode == cmt_pkg::CMT_MODE_OFF) begin
         st_next.cstat = CONTACT_FB;
      end

      // Lamp check forces every indicator on
      st_next.led = ctl.lamp_active ? all_leds : LED_REQ;
      ev[3] = ctl.lamp_done;

      // Sticky events, set beats clear
      st_next.ists = (st_reg.ists & ~clr) | ev;

      // Read data captured in the setup cycle
      if (setup) begin
         st_next.rdata = '0;
      end
      // Unmapped or misaligned reads stay zero
      if (setup && !unmapped) begin
         if (is_sel) begin
            st_next.rdata[`CMT_SEL_W-1:0] = st_reg.sel[sel_idx];
         end
         case (ofs)
            `CMT_OFS_OPTO:  st_next.rdata[`CMT_OPTO_W-1:0] = OPTO_IN;
            `CMT_OFS_CSTAT: st_next.rdata[`CMT_CONT_W-1:0] = st_reg.cstat;
            `CMT_OFS_PROBE: st_next.rdata[`CMT_NPROBE-1:0] = ctl.probe_val;
            `CMT_OFS_MODE:  st_next.rdata[1:0] = st_reg.mode;
            `CMT_OFS_MASK:  st_next.rdata[`CMT_CONT_W-1:0] = st_reg.mask;
            `CMT_OFS_CCMD:  st_next.rdata[1:0] = cmt_pkg::CMT_CC_IDLE;
            `CMT_OFS_LAMP:  st_next.rdata[0] = ctl.lamp_active | st_reg.lamp_go;
            `CMT_OFS_ISTS:  st_next.rdata[`CMT_EV_W-1:0] = st_reg.ists;
            `CMT_OFS_IMSK:  st_next.rdata[`CMT_EV_W-1:0] = st_reg.imask;
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // Outputs
   assign PRDATA = st_reg.rdata;
   assign CONTACT_OUT = st_reg.cout;
   assign PROBE_OUT = ctl.probe_val;
   assign LED_OUT = st_reg.led;
   assign OOS_LED = (st_reg.mode == cmt_pkg::CMT_MODE_OOS);
   assign PROT_OFF_ALARM = (st_reg.mode == cmt_pkg::CMT_MODE_OOS);
   assign MAINT_BLOCK = (st_reg.mode == cmt_pkg::CMT_MODE_OOS);
   assign CB_FREEZE = (st_reg.mode == cmt_pkg::CMT_MODE_OOS);
   assign TRANSMISSION_CAUSE_TEST = `CMT_IEC103 & (st_reg.mode == cmt_pkg::CMT_MODE_OOS);
   assign ALARM_REC = st_reg.alarm;
   assign IRQ = |(st_reg.ists & st_reg.imask);

   // ==========================================
   // Checks
   a_oos_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (st_reg.mode == cmt_pkg::CMT_MODE_OOS) |-> (OOS_LED && PROT_OFF_ALARM && MAINT_BLOCK
         && CB_FREEZE && CONTACT_OUT == '0 && TRANSMISSION_CAUSE_TEST == `CMT_IEC103))
      else $error("out-of-service outputs wrong");

   a_cb_frozen: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CB_FREEZE == (st_reg.mode == cmt_pkg::CMT_MODE_OOS) && MAINT_BLOCK == CB_FREEZE)
      else $error("breaker data not frozen");

   a_alarm_once: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && !unmapped && !bad_val && ofs == `CMT_OFS_MODE && PWDATA[1:0] == 2'h1
         && st_reg.mode == cmt_pkg::CMT_MODE_OFF) |=> ALARM_REC ##1 !ALARM_REC)
      else $error("alarm not recorded once");

   a_blk_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (st_reg.mode == cmt_pkg::CMT_MODE_BLK && !st_reg.ex_on) |-> CONTACT_OUT == '0)
      else $error("protection reached contacts while isolated");

   a_apply_pat: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && !unmapped && blk && ofs == `CMT_OFS_CCMD && PWDATA == 32'h00000001)
         |=> CONTACT_OUT == $past(st_reg.mask))
      else $error("exercise pattern not applied");

   a_remove_pat: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && !unmapped && blk && ofs == `CMT_OFS_CCMD && PWDATA == 32'h00000002)
         |=> CONTACT_OUT == '0 && !st_reg.ex_on)
      else $error("exercise not removed");

   a_ex_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (st_reg.ex_on && blk && !(wr && ofs == `CMT_OFS_CCMD) && !(wr && ofs == `CMT_OFS_MODE))
         |=> st_reg.ex_on && $stable(CONTACT_OUT))
      else $error("exercised contacts dropped");

   a_cmd_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (setup && ofs == `CMT_OFS_CCMD) |=> st_reg.rdata == 32'h00000000)
      else $error("contact command not idle");

   a_in_service: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (st_reg.mode == cmt_pkg::CMT_MODE_OFF) |-> CONTACT_OUT == $past(PROT_CONTACT_REQ) && !OOS_LED)
      else $error("normal service not restored");

   a_stat_frozen: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (st_reg.mode != cmt_pkg::CMT_MODE_OFF) |=> $stable(st_reg.cstat))
      else $error("contact status moved during test");

   a_sel_range: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && is_sel && PWDATA > 32'h000003FE) |-> PSLVERR ##1 $stable(st_reg.sel))
      else $error("out of range selector accepted");

   a_lamp_leds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ctl.lamp_active |=> LED_OUT == $past(all_leds))
      else $error("lamp check indicators not lit");

   a_opto_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (setup && !unmapped && ofs == `CMT_OFS_OPTO) |=> PRDATA == {18'h00000, $past(OPTO_IN)})
      else $error("opto status wrong");

   a_unmapped_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (setup && unmapped) |=> PRDATA == 32'h00000000)
      else $error("unmapped read not zero");

   a_mask_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && !unmapped && ofs == `CMT_OFS_MASK) |=> st_reg.mask == $past(PWDATA))
      else $error("pick mask not written");

   a_cmd_refused: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && !blk && ofs == `CMT_OFS_CCMD) |=> !st_reg.ex_on)
      else $error("contact command acted outside isolation");

   a_leave_blk: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (st_reg.mode != cmt_pkg::CMT_MODE_BLK) |-> !st_reg.ex_on)
      else $error("exercise outlived contact isolation");

   a_mode_refused: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && ofs == `CMT_OFS_MODE && PWDATA > 32'h00000002) |-> PSLVERR ##1 $stable(st_reg.mode))
      else $error("illegal test setting accepted");

   a_lamp_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (wr && !unmapped && ofs == `CMT_OFS_LAMP && PWDATA[0] && !ctl.lamp_active) |-> ##2 ctl.lamp_active)
      else $error("lamp check did not start");

   a_lamp_release: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $fell(ctl.lamp_active) |=> LED_OUT == $past(LED_REQ))
      else $error("indicators not released after lamp check");

   a_event_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (ev != '0) |=> (st_reg.ists & $past(ev)) == $past(ev))
      else $error("event not latched in status");

endmodule

// ---- test/cmt_partner.sv ----
`timescale 1ns/1ps
`include "cmt_defines.svh"
// ==========================================
// Contacts and internal bus seen from the far side
module cmt_partner (
   input  wire logic                   sys_clk,
   input  wire logic [`CMT_CONT_W-1:0] contact_drive,
   input  wire logic                   phase,
   output logic      [`CMT_CONT_W-1:0] contact_fb,
   output logic      [`CMT_BUS_W-1:0]  int_bus
);
   // Contacts follow their drive one cycle late
   always_ff @(posedge sys_clk) begin
      contact_fb <= contact_drive;
   end
   // Bus pattern known to the bench, flipped by phase
   always_comb begin
      for (int n = 0; n < `CMT_BUS_W; n++) begin
         int_bus[n] = ((n % 3) == 0) ^ phase;
      end
   end
endmodule

// ---- test/cmt_top_test.sv ----
`timescale 1ns/1ps
`include "cmt_defines.svh"
// ==========================================
// Self-checking bench for the commissioning controller
module cmt_top_test;
   localparam int unsigned LAMP = 20;
   logic        sys_clk, rst_n, psel, penable, pwrite, phase, variant_18;
   logic [11:0] paddr;
   logic [31:0] pwdata, prot_req, r32;
   logic [13:0] opto_in;
   logic [17:0] led_req, exp_all;
   wire  logic [31:0] prdata, contact_out, contact_fb;
   wire  logic        pready, pslverr, oos_led, prot_off, maint, cb_frz, transmission_cause, alarm_rec, irq;
   wire  logic [1022:0] int_bus;
   wire  logic [7:0]  probe_out;
   wire  logic [17:0] led_out;
   int mismatches, n_checks, n_alarm, lit_cnt;
   logic e;

   cmt_top #(.LAMP_CYCLES(LAMP)) cmt_top_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .OPTO_IN(opto_in), .CONTACT_FB(contact_fb),
      .PROT_CONTACT_REQ(prot_req), .CONTACT_OUT(contact_out), .INT_BUS(int_bus),
      .PROBE_OUT(probe_out), .LED_REQ(led_req), .VARIANT_18(variant_18), .LED_OUT(led_out),
      .OOS_LED(oos_led), .PROT_OFF_ALARM(prot_off), .MAINT_BLOCK(maint), .CB_FREEZE(cb_frz),
      .TRANSMISSION_CAUSE_TEST(transmission_cause), .ALARM_REC(alarm_rec), .IRQ(irq));
   cmt_partner cmt_partner_inst (.sys_clk(sys_clk), .contact_drive(contact_out), .phase(phase),
      .contact_fb(contact_fb), .int_bus(int_bus));

   // Clock, alarm pulse and lamp-lit counters
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (alarm_rec === 1'b1) n_alarm++;
      if (led_out === exp_all) lit_cnt++;
   end

   // ==========================================
   // Shared tasks
   task automatic print_verdict;
      if (mismatches == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {4'h0, a}; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk({31'h0, pready}, 32'h1);
      r32 = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
      apb(1, a, d);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(0, a, 32'h0);
      chk(r32, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask

   // ==========================================
   // Scenarios
   task automatic s_regs;
      rd(`CMT_OFS_MODE, 32'h0, 0);
      rd(8'h44, 32'h0, 1);
      wr(`CMT_OFS_MODE, 32'h3, 1);
      rd(`CMT_OFS_MODE, 32'h0, 0);
      wr(`CMT_OFS_SEL0, 32'h3FF, 1);
      rd(`CMT_OFS_SEL0, 32'h0, 0);
   endtask
   task automatic s_status;
      @(posedge sys_clk);
      opto_in <= 14'h2A5A; prot_req <= 32'h1234_5678;
      tick(4);
      chk(contact_out, 32'h1234_5678);
      rd(`CMT_OFS_OPTO, 32'h2A5A, 0);
      rd(`CMT_OFS_CSTAT, 32'h1234_5678, 0);
   endtask
   task automatic s_probe;
      logic [7:0] x;
      for (int i = 0; i < 8; i++) wr(`CMT_OFS_SEL0 + 8'(4 * i), 32'(i * 146), 0);
      for (int p = 0; p < 2; p++) begin
         @(posedge sys_clk);
         phase <= p[0];
         for (int i = 0; i < 8; i++) x[i] = (((i * 146) % 3) == 0) ^ p[0];
         tick(3);
         chk({24'h0, probe_out}, {24'h0, x});
         rd(`CMT_OFS_PROBE, {24'h0, x}, 0);
      end
   endtask
   task automatic s_oos;
      n_alarm = 0;
      wr(`CMT_OFS_MODE, 32'h1, 0);
      wr(`CMT_OFS_MASK, 32'hFFFF_FFFF, 0);
      wr(`CMT_OFS_CCMD, 32'h1, 0);
      tick(4);
      chk({27'h0, oos_led, prot_off, maint, cb_frz, transmission_cause}, 32'h1F);
      chk(contact_out, 32'h0);
      chk(n_alarm, 1);
      chk({31'h0, irq}, 32'h0);
      wr(`CMT_OFS_IMSK, 32'h1, 0);
      tick(1);
      chk({31'h0, irq}, 32'h1);
      rd(`CMT_OFS_CSTAT, 32'h1234_5678, 0);
      wr(`CMT_OFS_ISTS, 32'h1, 0);
      rd(`CMT_OFS_ISTS, 32'h0, 0);
      tick(1);
      chk({31'h0, irq}, 32'h0);
      wr(`CMT_OFS_MODE, 32'h0, 0);
      tick(3);
      chk({27'h0, oos_led, prot_off, maint, cb_frz, transmission_cause}, 32'h0);
      chk(contact_out, 32'h1234_5678);
   endtask
   task automatic s_exercise;
      wr(`CMT_OFS_MODE, 32'h2, 0);
      wr(`CMT_OFS_MASK, 32'hA5A5_0F0F, 0);
      tick(2);
      chk(contact_out, 32'h0);
      wr(`CMT_OFS_CCMD, 32'h1, 0);
      rd(`CMT_OFS_CCMD, 32'h0, 0);
      wr(`CMT_OFS_MASK, 32'h0000_0001, 0);
      tick(2);
      chk(contact_out, 32'hA5A5_0F0F);
      rd(`CMT_OFS_CSTAT, 32'h1234_5678, 0);
      wr(`CMT_OFS_CCMD, 32'h2, 0);
      rd(`CMT_OFS_CCMD, 32'h0, 0);
      chk(contact_out, 32'h0);
      rd(`CMT_OFS_ISTS, 32'h6, 0);
      wr(`CMT_OFS_CCMD, 32'h1, 0);
      tick(1);
      chk(contact_out, 32'h1);
      wr(`CMT_OFS_MODE, 32'h0, 0);
      tick(1);
      chk(contact_out, 32'h1234_5678);
      wr(`CMT_OFS_MODE, 32'h2, 0);
      tick(1);
      chk(contact_out, 32'h0);
      wr(`CMT_OFS_MODE, 32'h0, 0);
   endtask
   task automatic s_lamp(input logic v, input logic [17:0] all);
      @(posedge sys_clk);
      variant_18 <= v; led_req <= 18'h00005;
      wr(`CMT_OFS_ISTS, 32'hF, 0);
      tick(2);
      exp_all = all;
      lit_cnt = 0;
      wr(`CMT_OFS_LAMP, 32'h1, 0);
      tick(3);
      rd(`CMT_OFS_LAMP, 32'h1, 0);
      tick(LAMP + 8);
      chk(lit_cnt, LAMP);
      chk({14'h0, led_out}, {14'h0, 18'h00005});
      rd(`CMT_OFS_LAMP, 32'h0, 0);
      rd(`CMT_OFS_ISTS, 32'h8, 0);
   endtask

   // ==========================================
   // Reset, sequence and watchdog
   initial begin
      rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000; pwdata = 32'h0;
      phase = 0; variant_18 = 0; opto_in = 14'h0; prot_req = 32'h0; led_req = 18'h0;
      exp_all = 18'h0; mismatches = 0; n_checks = 0; n_alarm = 0; lit_cnt = 0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1;
      s_regs;
      s_status;
      s_probe;
      s_oos;
      s_exercise;
      s_lamp(0, `CMT_LED_ALL8);
      s_lamp(1, `CMT_LED_ALL18);
      print_verdict;
   end
   initial begin
      #100000;
      mismatches++;
      print_verdict;
   end
endmodule
